// >>> inc/blmi_pkg.sv
// Constants and types shared by the byte lane mask and inversion block
`default_nettype none
package blmi_pkg;
    // ===========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_MR1  = 8'h00;
    localparam logic [7:0] ADDR_MR5  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_CNT  = 8'h0C;
    localparam int         MR_W      = 18;
    localparam logic [17:0] MR_RESET = 18'h00000;
    // ===========================================================
    // Mode bit positions
    localparam int MR1_TDQS_BIT = 11;
    localparam int MR5_DM_BIT   = 10;
    localparam int MR5_WDBI_BIT = 11;
    localparam int MR5_RDBI_BIT = 12;
    // ===========================================================
    // Status fields
    localparam int STAT_CONF_BIT = 4;
    localparam int STAT_OVF_BIT  = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ===========================================================
    // Lane geometry
    localparam int BYTE_W     = 8;
    localparam int BURST_LEN  = 8;
    localparam int ZERO_LIMIT = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W     = 12;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    typedef struct packed {
        logic       keep;
        logic [7:0] data;
    } blmi_beat_t;
    typedef struct packed {
        logic tdqs;
        logic dm;
        logic wdbi;
        logic rdbi;
    } blmi_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR   = 3'b010,
        ST_RD   = 3'b100
    } blmi_state_t;
endpackage
`default_nettype wire

// >>> verilog/blmi_top.sv
// Byte lane mask, inversion and termination strobe logic with write FIFO
// What this block does
// - One shared pin, one write function only, read inversion beside it
// - Mask and inversion pin is active low
// - Termination strobe mode never drives the pin
// - Mode bits select termination, mask, inversions
// - Receiver off when both write functions off
// - Reads use only inversion on the pin
// - Read inversion off keeps driver off
// - Termination strobe disables mask and inversions
// - Strobe pins get data strobe termination
// - Mask low discards byte, high stores it
// - Inversion low inverts received byte
// - Read byte with over four zeros inverted
// - Write transfer carries byte plus pin bit
// - Read transfer carries byte plus indicator
`default_nettype none
module blmi_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0]   cnt, next_cnt;
    logic          push, pop;

    assign in_ready  = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr <= '0;
            rptr <= '0;
            cnt  <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt  <= next_cnt;
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule

module blmi_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Link pins
    input  wire logic        lk_strobe,
    input  wire logic        lk_wr_burst,
    input  wire logic        lk_rd_burst,
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic        dmi_n_i,
    output logic             dmi_n_o,
    output logic             dmi_n_oe,
    // Termination and receiver control
    input  wire logic        dqs_term_en,
    output logic             tdqs_term_en,
    output logic             dmi_rx_en,
    // Array side
    output logic             arr_wr_valid,
    input  wire logic        arr_wr_ready,
    output logic [7:0]       arr_wr_data,
    output logic             arr_wr_keep,
    input  wire logic        arr_rd_valid,
    output logic             arr_rd_ready,
    input  wire logic [7:0]  arr_rd_data
);
    // ===========================================================
    // Mode registers and effective functions
    logic [17:0]          mr1, mr5, next_mr1, next_mr5;
    blmi_pkg::blmi_mode_t mode;
    logic                 conflict;

    always_comb begin
        mode.tdqs = mr1[blmi_pkg::MR1_TDQS_BIT];
        mode.dm   = !mode.tdqs && mr5[blmi_pkg::MR5_DM_BIT];
        // Mask wins if software breaks the exclusion
        mode.wdbi = !mode.tdqs && !mr5[blmi_pkg::MR5_DM_BIT]
                    && mr5[blmi_pkg::MR5_WDBI_BIT];
        mode.rdbi = !mode.tdqs && mr5[blmi_pkg::MR5_RDBI_BIT];
    end
    assign conflict = mr5[blmi_pkg::MR5_DM_BIT] && mr5[blmi_pkg::MR5_WDBI_BIT];

    // ===========================================================
    // Pin synchronisers
    logic [11:0] sync1, sync2;
    logic        strobe_prev, link_edge;
    logic        s_strobe, s_wr, s_rd, s_dmi;
    logic [7:0]  s_dq;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1       <= '0;
            sync2       <= '0;
            strobe_prev <= 1'b0;
        end else begin
            sync1       <= {lk_strobe, lk_wr_burst, lk_rd_burst, dmi_n_i, dq_i};
            sync2       <= sync1;
            strobe_prev <= s_strobe;
        end
    end
    assign {s_strobe, s_wr, s_rd, s_dmi, s_dq} = sync2;
    // Both strobe edges carry a transfer
    assign link_edge = s_strobe ^ strobe_prev;

    // ===========================================================
    // Burst state
    blmi_pkg::blmi_state_t state, next_state;
    logic [2:0]            idx, next_idx;

    always_comb begin
        next_state = state;
        next_idx   = idx;
        unique case (state)
            blmi_pkg::ST_IDLE: begin
                if (s_wr) begin
                    next_state = blmi_pkg::ST_WR;
                end else if (s_rd) begin
                    next_state = blmi_pkg::ST_RD;
                end
                next_idx = '0;
            end
            blmi_pkg::ST_WR: begin
                if (!s_wr) begin
                    next_state = blmi_pkg::ST_IDLE;
                end else if (link_edge) begin
                    next_idx = idx + 3'h1;
                end
            end
            blmi_pkg::ST_RD: begin
                if (!s_rd) begin
                    next_state = blmi_pkg::ST_IDLE;
                end else if (link_edge) begin
                    next_idx = idx + 3'h1;
                end
            end
            default: begin
                next_state = blmi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= blmi_pkg::ST_IDLE;
            idx   <= '0;
        end else begin
            state <= next_state;
            idx   <= next_idx;
        end
    end

    // ===========================================================
    // Write path into FIFO
    blmi_pkg::blmi_beat_t wr_beat, fifo_out;
    logic                 wr_take, fifo_in_ready;

    assign wr_take = (state == blmi_pkg::ST_WR) && link_edge;
    always_comb begin
        wr_beat.keep = !(mode.dm && !s_dmi);
        wr_beat.data = (mode.wdbi && !s_dmi) ? ~s_dq : s_dq;
    end

    blmi_fifo #(
        .W     (blmi_pkg::BYTE_W + 1),
        .DEPTH (blmi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (wr_take),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_beat),
        .out_valid (arr_wr_valid),
        .out_ready (arr_wr_ready),
        .out_data  (fifo_out)
    );
    assign arr_wr_data = fifo_out.data;
    assign arr_wr_keep = fifo_out.keep;

    // ===========================================================
    // Read path and pin drivers
    logic [7:0] next_dq_o;
    logic       next_dmi_n_o, rd_inv, next_term;

    assign arr_rd_ready = (state == blmi_pkg::ST_RD) && link_edge;
    assign rd_inv = mode.rdbi && ($countones(~arr_rd_data) > blmi_pkg::ZERO_LIMIT);

    always_comb begin
        next_dq_o    = dq_o;
        next_dmi_n_o = dmi_n_o;
        if (arr_rd_ready && arr_rd_valid) begin
            next_dq_o    = rd_inv ? ~arr_rd_data : arr_rd_data;
            next_dmi_n_o = !rd_inv;
        end
        next_term = mode.tdqs && dqs_term_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_o         <= '0;
            dmi_n_o      <= 1'b1;
            tdqs_term_en <= 1'b0;
        end else begin
            dq_o         <= next_dq_o;
            dmi_n_o      <= next_dmi_n_o;
            tdqs_term_en <= next_term;
        end
    end
    assign dq_oe     = (state == blmi_pkg::ST_RD);
    assign dmi_n_oe  = (state == blmi_pkg::ST_RD) && mode.rdbi;
    assign dmi_rx_en = mode.dm || mode.wdbi;

    // ===========================================================
    // Status and counters
    logic        ovf, next_ovf;
    logic [15:0] n_xfer, n_mask, next_n_xfer, next_n_mask;
    logic        ovf_clr;

    always_comb begin
        next_n_xfer = n_xfer;
        next_n_mask = n_mask;
        if (wr_take) begin
            next_n_xfer = n_xfer + 16'h0001;
            if (!wr_beat.keep) begin
                next_n_mask = n_mask + 16'h0001;
            end
        end
        next_ovf = (ovf && !ovf_clr) || (wr_take && !fifo_in_ready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf    <= 1'b0;
            n_xfer <= blmi_pkg::CNT_RESET;
            n_mask <= blmi_pkg::CNT_RESET;
        end else begin
            ovf    <= next_ovf;
            n_xfer <= next_n_xfer;
            n_mask <= next_n_mask;
        end
    end

    // ===========================================================
    // AXI4-Lite write channel
    logic        aw_held, w_held, next_aw_held, next_w_held, next_bvalid;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic [1:0]  next_bresp;
    logic        do_wr;
    logic [31:0] wmask;

    assign awready = !aw_held;
    assign wready  = !w_held;
    assign do_wr   = aw_held && w_held && !bvalid;
    assign ovf_clr = do_wr && (aw_addr == blmi_pkg::ADDR_STAT)
                     && w_strb[1] && w_data[blmi_pkg::STAT_OVF_BIT];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb[i]}};
        end
        next_aw_held = aw_held || awvalid;
        next_aw_addr = awvalid && !aw_held ? awaddr : aw_addr;
        next_w_held  = w_held || wvalid;
        next_w_data  = wvalid && !w_held ? wdata : w_data;
        next_w_strb  = wvalid && !w_held ? wstrb : w_strb;
        next_bvalid  = bvalid && !bready;
        next_bresp   = bresp;
        next_mr1     = mr1;
        next_mr5     = mr5;
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = blmi_pkg::RESP_OKAY;
            unique case (aw_addr)
                blmi_pkg::ADDR_MR1:
                    next_mr1 = ((mr1 & ~wmask[17:0]) | (w_data[17:0] & wmask[17:0]));
                blmi_pkg::ADDR_MR5:
                    next_mr5 = ((mr5 & ~wmask[17:0]) | (w_data[17:0] & wmask[17:0]));
                blmi_pkg::ADDR_STAT, blmi_pkg::ADDR_CNT: ;
                default: next_bresp = blmi_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            bvalid  <= 1'b0;
            bresp   <= blmi_pkg::RESP_OKAY;
            mr1     <= blmi_pkg::MR_RESET;
            mr5     <= blmi_pkg::MR_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            mr1     <= next_mr1;
            mr5     <= next_mr5;
        end
    end

    // ===========================================================
    // AXI4-Lite read channel
    logic        next_rvalid;
    logic [31:0] next_rdata, stat_word;
    logic [1:0]  next_rresp;

    assign arready = !rvalid;
    always_comb begin
        stat_word = '0;
        stat_word[3:0] = {mode.tdqs, mode.dm, mode.wdbi, mode.rdbi};
        stat_word[blmi_pkg::STAT_CONF_BIT] = conflict;
        stat_word[blmi_pkg::STAT_OVF_BIT]  = ovf;
        stat_word[18:16] = idx;
        stat_word[26:24] = state;
        next_rvalid = rvalid && !rready;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = blmi_pkg::RESP_OKAY;
            unique case (araddr)
                blmi_pkg::ADDR_MR1:  next_rdata = {14'h0000, mr1};
                blmi_pkg::ADDR_MR5:  next_rdata = {14'h0000, mr5};
                blmi_pkg::ADDR_STAT: next_rdata = stat_word;
                blmi_pkg::ADDR_CNT:  next_rdata = {n_mask, n_xfer};
                default: begin
                    next_rdata = '0;
                    next_rresp = blmi_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= blmi_pkg::RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ===========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tdqs_no_drive_a: assert property (dmi_n_oe |-> !mr1[blmi_pkg::MR1_TDQS_BIT])
        else $error("pin driven in strobe mode");
    one_function_a: assert property (mr1[blmi_pkg::MR1_TDQS_BIT] |->
        !(dmi_n_oe || dmi_rx_en || mode.dm || mode.wdbi || mode.rdbi))
        else $error("function active with strobe mode");
    mode_decode_a: assert property (dmi_rx_en ==
        (!mr1[blmi_pkg::MR1_TDQS_BIT] &&
         (mr5[blmi_pkg::MR5_DM_BIT] || mr5[blmi_pkg::MR5_WDBI_BIT])))
        else $error("receiver decode wrong");
    rx_off_a: assert property (!(mode.dm || mode.wdbi) |-> !dmi_rx_en)
        else $error("receiver on with no write function");
    rd_drv_off_a: assert property ((state == blmi_pkg::ST_RD && !mode.rdbi) |-> !dmi_n_oe)
        else $error("driver on without read inversion");
    term_follow_a: assert property (##1 tdqs_term_en == $past(mode.tdqs && dqs_term_en))
        else $error("strobe termination mismatch");
    mask_drop_a: assert property ((wr_take && mode.dm && !s_dmi) |-> !wr_beat.keep)
        else $error("masked byte kept");
    wr_invert_a: assert property ((wr_take && mode.wdbi) |->
        wr_beat.data == (s_dmi ? s_dq : ~s_dq))
        else $error("write inversion wrong");
    rd_invert_a: assert property ((arr_rd_ready && arr_rd_valid && mode.rdbi) |=>
        (!dmi_n_o == ($countones(~$past(arr_rd_data)) > 4)) &&
        (dq_o == (dmi_n_o ? $past(arr_rd_data) : ~$past(arr_rd_data))))
        else $error("read inversion wrong");
    burst_step_a: assert property ((state == blmi_pkg::ST_WR && s_wr && link_edge) |=>
        idx == 3'($past(idx) + 3'h1))
        else $error("burst index not stepped");

    cov_masked_c: cover property (wr_take && !wr_beat.keep);
    cov_rd_inv_c: cover property (arr_rd_ready && arr_rd_valid && rd_inv);
    cov_full_c:   cover property (wr_take && !fifo_in_ready);
    cov_tdqs_c:   cover property (tdqs_term_en);
endmodule
`default_nettype wire

// >>> bench/blmi_ctrl_model.sv
// Controller model driving the link side of one byte lane
`default_nettype none
module blmi_ctrl_model (
    // Clock
    input  wire logic  aclk,
    // Link pins
    output var logic       lk_strobe,
    output var logic       lk_wr_burst,
    output var logic       lk_rd_burst,
    output var logic [7:0] dq_i,
    output var logic       dmi_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lk_strobe = 1'b0;
        lk_wr_burst = 1'b0;
        lk_rd_burst = 1'b0;
        dq_i = 8'hFF;
        dmi_n_i = 1'b1;
    end
    task automatic start(input logic wr);
        @(posedge aclk);
        if (wr)
            lk_wr_burst <= 1'b1;
        else
            lk_rd_burst <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    // Byte and active-low pin bit per strobe edge, half period 100 ns
    task automatic xfer(input logic [7:0] d, input logic p);
        @(posedge aclk);
        dq_i <= d;
        dmi_n_i <= p;
        repeat (2) @(posedge aclk);
        lk_strobe <= ~lk_strobe;
        @(posedge aclk);
    endtask
    // Strobe stands still; lane floats to the high termination rail
    task automatic stop();
        repeat (3) @(posedge aclk);
        lk_wr_burst <= 1'b0;
        lk_rd_burst <= 1'b0;
        dq_i <= 8'hFF;
        dmi_n_i <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the byte lane mask and inversion block
`default_nettype none
`define CHK(n, g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, lk_strobe, lk_wr_burst, lk_rd_burst;
    logic        dq_oe, dmi_n_i, dmi_n_o, dmi_n_oe, dqs_term_en, tdqs_term_en, dmi_rx_en;
    logic        arr_wr_valid, arr_wr_ready, arr_wr_keep, arr_rd_valid, arr_rd_ready;
    logic [7:0]  awaddr, araddr, dq_i, dq_o, arr_wr_data, arr_rd_data;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          num_errors, tests_run;
    int          cyc = 0;
    logic [7:0]  rd_tab[8] = '{8'h00, 8'h0F, 8'h07, 8'hFF, 8'h10, 8'hF0, 8'h01, 8'h7F};
    blmi_pkg::blmi_beat_t exp_q[$], got_q[$];
    blmi_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .lk_strobe(lk_strobe), .lk_wr_burst(lk_wr_burst), .lk_rd_burst(lk_rd_burst),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_n_i(dmi_n_i), .dmi_n_o(dmi_n_o),
        .dmi_n_oe(dmi_n_oe), .dqs_term_en(dqs_term_en), .tdqs_term_en(tdqs_term_en),
        .dmi_rx_en(dmi_rx_en), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
        .arr_wr_data(arr_wr_data), .arr_wr_keep(arr_wr_keep), .arr_rd_valid(arr_rd_valid),
        .arr_rd_ready(arr_rd_ready), .arr_rd_data(arr_rd_data)
    );
    blmi_ctrl_model ctrl_u (
        .aclk(aclk), .lk_strobe(lk_strobe), .lk_wr_burst(lk_wr_burst),
        .lk_rd_burst(lk_rd_burst), .dq_i(dq_i), .dmi_n_i(dmi_n_i)
    );
    // ====
    // Clock, array capture and watchdog
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (arr_wr_valid && arr_wr_ready)
            got_q.push_back({arr_wr_keep, arr_wr_data});
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ====
    // Bus tasks
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        `CHK("bresp", bresp, er)
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // ====
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        `CHK("tdqs", tdqs_term_en, 1'b0)
        `CHK("rx_en", dmi_rx_en, 1'b0)
        `CHK("rd_oe", dmi_n_oe, 1'b0)
        axi_rd(blmi_pkg::ADDR_MR5, d, r);
        `CHK("mr5", d, 32'h0)
        axi_wr(8'h10, 32'h1, blmi_pkg::RESP_SLVERR);
        axi_rd(8'h10, d, r);
        `CHK("rresp", r, blmi_pkg::RESP_SLVERR)
        `CHK("rdata", d, 32'h0)
        axi_wr(blmi_pkg::ADDR_MR5, 32'hFFFFF3FF, blmi_pkg::RESP_OKAY);
        axi_rd(blmi_pkg::ADDR_MR5, d, r);
        `CHK("mr5", d, 32'h0003F3FF)
        $display("regs done");
    endtask
    task automatic t_wr(input logic [17:0] mr5, input int n, input logic [7:0] pins);
        logic [7:0] b;
        logic       p;
        axi_wr(blmi_pkg::ADDR_MR5, 32'(mr5), blmi_pkg::RESP_OKAY);
        @(posedge aclk);
        `CHK("rx_en", dmi_rx_en, mr5[10] | mr5[11])
        ctrl_u.start(1'b1);
        for (int i = 0; i < n; i++) begin
            b = 8'h3C + 8'(i * 37);
            p = pins[i % 8];
            ctrl_u.xfer(b, p);
            if (exp_q.size() < blmi_pkg::FIFO_DEPTH)
                exp_q.push_back({~(mr5[10] & ~p), (mr5[11] & ~p) ? ~b : b});
        end
        ctrl_u.stop();
    endtask
    task automatic chk_q();
        blmi_pkg::blmi_beat_t e, g;
        repeat (24) @(posedge aclk);
        `CHK("beats", got_q.size(), exp_q.size())
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            `CHK("keep", g.keep, e.keep)
            if (e.keep) `CHK("byte", g.data, e.data)
        end
        exp_q.delete();
        got_q.delete();
        $display("write burst done");
    endtask
    task automatic t_rd(input logic [17:0] mr5);
        logic [7:0] b;
        logic       inv;
        axi_wr(blmi_pkg::ADDR_MR5, 32'(mr5), blmi_pkg::RESP_OKAY);
        ctrl_u.start(1'b0);
        @(posedge aclk);
        `CHK("dq_oe", dq_oe, 1'b1)
        `CHK("rd_oe", dmi_n_oe, mr5[12])
        for (int i = 0; i < 8; i++) begin
            b = rd_tab[i];
            inv = mr5[12] && ($countones(b) < 4);
            arr_rd_data <= b;
            ctrl_u.xfer(8'hFF, 1'b1);
            repeat (5) @(posedge aclk);
            `CHK("dq_o", dq_o, inv ? ~b : b)
            if (mr5[12]) `CHK("dbi_n", dmi_n_o, ~inv)
        end
        ctrl_u.stop();
        $display("read burst done");
    endtask
    task automatic t_term();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(blmi_pkg::ADDR_MR1, 32'h800, blmi_pkg::RESP_OKAY);
        axi_wr(blmi_pkg::ADDR_MR5, 32'h1400, blmi_pkg::RESP_OKAY);
        axi_rd(blmi_pkg::ADDR_STAT, d, r);
        `CHK("modes", d[3:0], 4'h8)
        `CHK("rx_en", dmi_rx_en, 1'b0)
        `CHK("tdqs", tdqs_term_en, 1'b1)
        dqs_term_en <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("tdqs", tdqs_term_en, 1'b0)
        ctrl_u.start(1'b0);
        @(posedge aclk);
        `CHK("rd_oe", dmi_n_oe, 1'b0)
        ctrl_u.stop();
        $display("termination done");
    endtask
    task automatic t_ovf();
        logic [31:0] d;
        logic [1:0]  r;
        arr_wr_ready <= 1'b0;
        t_wr(18'h00800, 17, 8'h5A);
        axi_rd(blmi_pkg::ADDR_STAT, d, r);
        `CHK("ovf", d[8], 1'b1)
        axi_rd(blmi_pkg::ADDR_CNT, d, r);
        `CHK("cnt", d, 32'h00040029)
        arr_wr_ready <= 1'b1;
        chk_q();
        axi_wr(blmi_pkg::ADDR_STAT, 32'h100, blmi_pkg::RESP_OKAY);
        axi_rd(blmi_pkg::ADDR_STAT, d, r);
        `CHK("ovf", d[8], 1'b0)
        $display("overflow done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, arr_rd_data} = '0;
        arr_wr_ready = 1'b1;
        arr_rd_valid = 1'b1;
        dqs_term_en = 1'b1;
        num_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_regs();
        t_wr(18'h00400, 8, 8'hB2);
        chk_q();
        t_wr(18'h00800, 8, 8'hB2);
        chk_q();
        t_wr(18'h00000, 8, 8'h00);
        chk_q();
        t_ovf();
        t_rd(18'h01000);
        t_rd(18'h00400);
        t_term();
        give_verdict();
    end
endmodule
`default_nettype wire
